// *** core/sdils_map.svh ***
// Register map, field positions, reset values and timing constants of the input monitor
// Functional notes
// RULE_01: Select pin high gives pin-only control; low gives host-register control.
// RULE_02: Equalizer enable pin low or open sets that input's equalization low.
// RULE_03: Equalizer enable pin high on the selected input sets medium equalization.
// RULE_04: Pin-only mode: data-in, data-out, clock, chip-select pins enable channels 0..3.
// RULE_05: Two-bit select 00,01,10,11 routes input 0,1,2,3.
// RULE_06: Open select pins read low, defaulting toward input 0.
// RULE_07: Only the selected input keeps buffer and equalizer powered; others off.
// RULE_08: Loss flag rises only after 5 to 10 us without transitions.
// RULE_09: Asserted loss flag falls within 0 to 5 us of a transition.
// RULE_10: Loss flag high when window edge count below threshold, low above.
// RULE_11: Serial output is muted while loss of signal is detected.
// RULE_12: Loss detection runs in every operating mode.
// RULE_13: Two methods: slicer edge count, or amplitude-and-duration qualified edges.
// RULE_14: Host picks method 1 and threshold 0 (large) to 3 (small) signals.
// RULE_15: Method and threshold live in the top control register at 0x02.
// RULE_16: Retimed data at three rates with 0.8 UI jitter tolerance.
// RULE_17: Reference holds the internal clock near rate while no input present.
// RULE_18: Lock flag high only while frequency and phase monitors agree.
// RULE_19: Harmonic lock is detected and never reported as lock.
// RULE_20: Lock state is readable through the host register.
// RULE_21: Lock detection runs from reset onward and re-evaluates on interruption.
// RULE_22: Lock is reached within 1 ms of a new signal or rate.
// RULE_23: Loss and edge windows are timed by counters on the reference timebase.
`ifndef SDILS_MAP_SVH
`define SDILS_MAP_SVH

// ==========================================================
// Register map
`define SDILS_ADDR_TOP      8'h02
`define SDILS_TOP_RST       16'h0008
`define SDILS_F_METHOD      0
`define SDILS_F_THR_LO      1
`define SDILS_F_THR_HI      2
`define SDILS_F_EQ_LO       3
`define SDILS_F_EQ_HI       4
`define SDILS_F_OVERRUN     13
`define SDILS_F_LOS         14
`define SDILS_F_LOCKED      15
`define SDILS_RD_ZERO       8'h00
`define SDILS_RD_NONE       16'h0000

// ==========================================================
// Timing
`define SDILS_CLK_MHZ       40
`define SDILS_LOS_WIN_NS    5000
`define SDILS_LOS_WIN_CYC   8'((`SDILS_LOS_WIN_NS * `SDILS_CLK_MHZ) / 1000)
`define SDILS_LOCK_QUAL_NS  10000
`define SDILS_LOCK_QUAL_CYC 10'((`SDILS_LOCK_QUAL_NS * `SDILS_CLK_MHZ) / 1000)
`define SDILS_LOCK_TMO_US   1000
`define SDILS_AMP_HOLD_CYC  2'h2

// ==========================================================
// Data path
`define SDILS_LOS_EDGE_MIN  8'h01
`define SDILS_WORD_W        8
`define SDILS_FIFO_DEPTH    4
`define SDILS_MUTE_WORD     8'hff
`define SDILS_PIN_W         18

`endif

// *** core/sdils_pkg.sv ***
// Types shared by the input monitor modules
package sdils_pkg;

   typedef enum logic [1:0]
   {
      SDILS_EQ_OFF  = 2'b00,
      SDILS_EQ_LOW  = 2'b01,
      SDILS_EQ_MED  = 2'b10,
      SDILS_EQ_HIGH = 2'b11
   } sdils_eq_type;

   typedef enum logic [1:0]
   {
      SDILS_LK_IDLE   = 2'b00,
      SDILS_LK_QUAL   = 2'b01,
      SDILS_LK_LOCKED = 2'b10
   } sdils_lock_type;

   typedef enum logic
   {
      SDILS_LOS_EDGE = 1'b0,
      SDILS_LOS_AMP  = 1'b1
   } sdils_method_type;

endpackage

// *** core/sdils_sync3.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sdils_sync3
   import sdils_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] agree;

   // First stage feeds only the second
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign agree = ~(s2 ^ s3);

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         q_o <= '0;
      else
         q_o <= (agree & s3) | (~agree & q_o);
   end

endmodule // sdils_sync3
`default_nettype wire

// *** core/sdils_fifo.sv ***
// Word FIFO with registered head, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdils_fifo
   import sdils_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output var  logic             in_ready_o,
   output var  logic [WIDTH-1:0] out_data_o,
   output var  logic             out_valid_o,
   input  wire logic             out_ready_i,
   output var  logic             full_o,
   output var  logic             empty_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign full_o     = (count == (AW+1)'(DEPTH));
   assign empty_o    = (count == '0);
   assign in_ready_o = !full_o;
   assign push       = in_valid_i && !full_o;
   assign pop        = !empty_o && (!out_valid_o || out_ready_i);

   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Head register keeps the consumer port straight from flops
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         out_data_o  <= '0;
         out_valid_o <= 1'b0;
      end
      else if (pop)
      begin
         out_data_o  <= mem[rd_ptr];
         out_valid_o <= 1'b1;
      end
      else if (out_ready_i)
         out_valid_o <= 1'b0;
   end

endmodule // sdils_fifo
`default_nettype wire

// *** core/sdils_top.sv ***
// Input select, equalizer enables, loss-of-signal and lock monitor
`include "sdils_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sdils_top
   import sdils_pkg::*;
#(
   parameter int unsigned LOCK_TIMEOUT_CYC = `SDILS_LOCK_TMO_US * `SDILS_CLK_MHZ
)
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        host_interface_select_n_i,
   input  wire logic        spi_mosi_eq0_i,
   input  wire logic        spi_miso_eq1_i,
   input  wire logic        spi_sck_eq2_i,
   input  wire logic        spi_cs_eq3_i,
   input  wire logic [1:0]  input_channel_select_i,
   input  wire logic        serial_input_0_i,
   input  wire logic        serial_input_1_i,
   input  wire logic        serial_input_2_i,
   input  wire logic        serial_input_3_i,
   input  wire logic [3:0]  amp_ok_i,
   input  wire logic        pll_freq_ok_i,
   input  wire logic        pll_phase_ok_i,
   input  wire logic        pll_harmonic_i,
   input  wire logic        host_wr_i,
   input  wire logic [7:0]  host_addr_i,
   input  wire logic [15:0] host_wdata_i,
   output var  logic [15:0] host_rdata_o,
   output var  logic [3:0]  input_buffer_enable_o,
   output var  logic [7:0]  eq_level_o,
   output var  logic [1:0]  los_threshold_o,
   output var  logic        los_method_o,
   output var  logic        signal_loss_flag_o,
   output var  logic        data_mute_o,
   output var  logic        locked_o,
   output var  logic        ref_hold_o,
   output var  logic        lock_retry_o,
   output var  logic [7:0]  out_data_o,
   output var  logic        out_valid_o,
   input  wire logic        out_ready_i
);

   // ==========================================================
   // Pin synchronisers
   logic [`SDILS_PIN_W-1:0] pins_raw;
   logic [`SDILS_PIN_W-1:0] pins;
   logic                    legacy;
   logic [3:0]              eq_pin;
   logic [1:0]              sel;
   logic [3:0]              ser;
   logic [3:0]              amp;
   logic                    freq_ok;
   logic                    phase_ok;
   logic                    harmonic;

   assign pins_raw = {pll_harmonic_i, pll_phase_ok_i, pll_freq_ok_i, amp_ok_i,
                      serial_input_3_i, serial_input_2_i, serial_input_1_i,
                      serial_input_0_i, input_channel_select_i,
                      spi_cs_eq3_i, spi_sck_eq2_i, spi_miso_eq1_i, spi_mosi_eq0_i,
                      host_interface_select_n_i};

   // Reset value zero keeps an open select at input 0 [RULE_06]
   sdils_sync3 #(
      .W (`SDILS_PIN_W)
   ) u_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .d_i     (pins_raw),
      .q_o     (pins)
   );

   assign legacy   = pins[0];      // [RULE_01]
   assign eq_pin   = pins[4:1];    // [RULE_04]
   assign sel      = pins[6:5];
   assign ser      = pins[10:7];
   assign amp      = pins[14:11];
   assign freq_ok  = pins[15];
   assign phase_ok = pins[16];
   assign harmonic = pins[17];

   // ==========================================================
   // Control register
   logic             method;
   logic [1:0]       thr_adj;
   sdils_eq_type     host_eq;
   logic             overrun;
   logic             overrun_set;
   logic             top_wr;
   sdils_method_type eff_method;
   localparam logic [15:0] TOP_RST = `SDILS_TOP_RST;

   assign top_wr = host_wr_i && !legacy && (host_addr_i == `SDILS_ADDR_TOP);   // [RULE_15]

   // Pin-only mode pins the settings at defaults so the part is live
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         method  <= TOP_RST[`SDILS_F_METHOD];
         thr_adj <= TOP_RST[`SDILS_F_THR_HI:`SDILS_F_THR_LO];
         host_eq <= sdils_eq_type'(TOP_RST[`SDILS_F_EQ_HI:`SDILS_F_EQ_LO]);
      end
      else if (legacy)
      begin
         method  <= TOP_RST[`SDILS_F_METHOD];
         thr_adj <= TOP_RST[`SDILS_F_THR_HI:`SDILS_F_THR_LO];
         host_eq <= sdils_eq_type'(TOP_RST[`SDILS_F_EQ_HI:`SDILS_F_EQ_LO]);
      end
      else if (top_wr)
      begin
         method  <= host_wdata_i[`SDILS_F_METHOD];                   // [RULE_15]
         thr_adj <= host_wdata_i[`SDILS_F_THR_HI:`SDILS_F_THR_LO];   // [RULE_15]
         host_eq <= sdils_eq_type'(host_wdata_i[`SDILS_F_EQ_HI:`SDILS_F_EQ_LO]);
      end
   end

   // Legacy mode always uses the slicer edge detector
   assign eff_method = legacy ? SDILS_LOS_EDGE : sdils_method_type'(method);   // [RULE_13]

   // Sticky overrun, a new event beats a same-cycle clear
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         overrun <= 1'b0;
      else if (overrun_set)
         overrun <= 1'b1;
      else if (top_wr && host_wdata_i[`SDILS_F_OVERRUN])
         overrun <= 1'b0;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         host_rdata_o <= `SDILS_RD_NONE;
      else if (host_addr_i == `SDILS_ADDR_TOP)
         host_rdata_o <= {locked_o, signal_loss_flag_o, overrun,       // [RULE_20]
                          `SDILS_RD_ZERO, host_eq, thr_adj, method};
      else
         host_rdata_o <= `SDILS_RD_NONE;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         los_threshold_o <= '0;
         los_method_o    <= 1'b0;
      end
      else
      begin
         los_threshold_o <= thr_adj;
         los_method_o    <= eff_method;
      end
   end

   // ==========================================================
   // Input select and equalizer enables
   for (genvar ch = 0; ch < 4; ch++)
   begin : g_chan
      always_ff @(posedge mclk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            input_buffer_enable_o[ch] <= 1'b0;
            eq_level_o[2*ch +: 2]     <= SDILS_EQ_OFF;
         end
         else if (sel != 2'(ch))                                      // [RULE_05]
         begin
            input_buffer_enable_o[ch] <= 1'b0;                        // [RULE_07]
            eq_level_o[2*ch +: 2]     <= SDILS_EQ_OFF;                // [RULE_07]
         end
         else
         begin
            input_buffer_enable_o[ch] <= 1'b1;
            if (!legacy)
               eq_level_o[2*ch +: 2] <= host_eq;
            else if (eq_pin[ch])
               eq_level_o[2*ch +: 2] <= SDILS_EQ_MED;                 // [RULE_03]
            else
               eq_level_o[2*ch +: 2] <= SDILS_EQ_LOW;                 // [RULE_02]
         end
      end
   end

   // ==========================================================
   // Edge detection on the selected input
   logic [3:0] ser_d;
   logic [1:0] sel_d;
   logic       sel_chg;
   logic       edge_sel;
   logic [1:0] amp_run;
   logic       amp_long;
   logic       edge_q;

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ser_d <= '0;
         sel_d <= '0;
      end
      else
      begin
         ser_d <= ser;
         sel_d <= sel;
      end
   end

   assign sel_chg  = (sel != sel_d);
   assign edge_sel = ser[sel] ^ ser_d[sel];

   // Duration check rejects short crosstalk bursts
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         amp_run <= '0;
      else if (sel_chg || !amp[sel])
         amp_run <= '0;
      else if (amp_run != `SDILS_AMP_HOLD_CYC)
         amp_run <= amp_run + 2'h1;
   end

   assign amp_long = (amp_run == `SDILS_AMP_HOLD_CYC);
   assign edge_q   = (eff_method == SDILS_LOS_AMP) ? (edge_sel && amp_long) : edge_sel;   // [RULE_13]

   // ==========================================================
   // Loss-of-signal windows
   logic [7:0] win_cnt;
   logic [7:0] edge_cnt;
   logic [7:0] next_edge_cnt;
   logic       win_end;

   assign win_end       = (win_cnt == `SDILS_LOS_WIN_CYC - 8'h01);
   assign next_edge_cnt = (edge_q && edge_cnt != 8'hff) ? edge_cnt + 8'h01 : edge_cnt;

   // Window counter never gated by mode [RULE_12]
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         win_cnt <= '0;
      else if (sel_chg || win_end)
         win_cnt <= '0;                                               // [RULE_23]
      else
         win_cnt <= win_cnt + 8'h01;                                  // [RULE_23]
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         edge_cnt <= '0;
      else if (sel_chg || win_end)
         edge_cnt <= '0;
      else
         edge_cnt <= next_edge_cnt;
   end

   // A whole quiet window of 5 us bounds the silence between 5 and 10 us
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         signal_loss_flag_o <= 1'b0;
      else if (sel_chg)
         signal_loss_flag_o <= signal_loss_flag_o;
      else if (next_edge_cnt >= `SDILS_LOS_EDGE_MIN)
         signal_loss_flag_o <= 1'b0;                                  // [RULE_09] [RULE_10]
      else if (win_end)
         signal_loss_flag_o <= 1'b1;                                  // [RULE_08] [RULE_10]
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         data_mute_o <= 1'b0;
      else
         data_mute_o <= signal_loss_flag_o;                           // [RULE_11]
   end

   // ==========================================================
   // Retimed data words toward the output stage
   logic [`SDILS_WORD_W-1:0] shift;
   logic [2:0]               bit_cnt;
   logic [`SDILS_WORD_W-1:0] pend_word;
   logic                     pend_valid;
   logic                     fifo_ready;
   logic                     stall;

   // Packer stops on the eighth bit while the FIFO refuses; lost bits flag an overrun
   assign stall       = pend_valid && !fifo_ready;
   assign overrun_set = stall && (bit_cnt == 3'h7);

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         shift   <= '0;
         bit_cnt <= '0;
      end
      else if (!(stall && bit_cnt == 3'h7))
      begin
         shift   <= {shift[`SDILS_WORD_W-2:0], ser[sel]};             // [RULE_16]
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pend_word  <= '0;
         pend_valid <= 1'b0;
      end
      else if (bit_cnt == 3'h7 && !stall)
      begin
         pend_word  <= data_mute_o ? `SDILS_MUTE_WORD                  // [RULE_11]
                                   : {shift[`SDILS_WORD_W-2:0], ser[sel]};
         pend_valid <= 1'b1;
      end
      else if (fifo_ready)
         pend_valid <= 1'b0;
   end

   sdils_fifo #(
      .WIDTH (`SDILS_WORD_W),
      .DEPTH (`SDILS_FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (pend_word),
      .in_valid_i  (pend_valid),
      .in_ready_o  (fifo_ready),
      .out_data_o  (out_data_o),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .full_o      (),
      .empty_o     ()
   );

   // ==========================================================
   // Lock detection
   sdils_lock_type lk_state;
   logic [9:0]     qual_cnt;
   logic [15:0]    tmo_cnt;
   logic           lk_ok;
   logic           tmo_hit;

   assign lk_ok   = freq_ok && phase_ok && !harmonic && !signal_loss_flag_o;   // [RULE_18] [RULE_19]
   assign tmo_hit = (tmo_cnt == 16'(LOCK_TIMEOUT_CYC - 1));

   // Starts from reset and never stops; any upset sends it back to search
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         lk_state <= SDILS_LK_IDLE;                                   // [RULE_21]
      else if (sel_chg || !lk_ok)
         lk_state <= SDILS_LK_IDLE;                                   // [RULE_21]
      else
      begin
         unique case (lk_state)
            SDILS_LK_IDLE:
               lk_state <= SDILS_LK_QUAL;
            SDILS_LK_QUAL:
               if (qual_cnt == `SDILS_LOCK_QUAL_CYC - 10'h001)
                  lk_state <= SDILS_LK_LOCKED;                        // [RULE_18]
            SDILS_LK_LOCKED:
               lk_state <= SDILS_LK_LOCKED;
            default:
               lk_state <= SDILS_LK_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         qual_cnt <= '0;
      else if (lk_state != SDILS_LK_QUAL)
         qual_cnt <= '0;
      else
         qual_cnt <= qual_cnt + 10'h001;
   end

   // Qualification is far shorter than the 1 ms budget; retry kicks the search
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tmo_cnt      <= '0;
         lock_retry_o <= 1'b0;
      end
      else if (lk_state == SDILS_LK_LOCKED || sel_chg)
      begin
         tmo_cnt      <= '0;
         lock_retry_o <= 1'b0;
      end
      else
      begin
         tmo_cnt      <= tmo_hit ? '0 : tmo_cnt + 16'h0001;           // [RULE_22]
         lock_retry_o <= tmo_hit;                                     // [RULE_22]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         locked_o   <= 1'b0;
         ref_hold_o <= 1'b1;
      end
      else
      begin
         locked_o   <= (lk_state == SDILS_LK_LOCKED);                 // [RULE_18]
         ref_hold_o <= (lk_state != SDILS_LK_LOCKED);                 // [RULE_17]
      end
   end

endmodule // sdils_top
`default_nettype wire

// *** tb/sdils_top_asserts.sv ***
// Concurrent checks on the input monitor top ports
`timescale 1ns/1ps
`default_nettype none
module sdils_top_asserts
(
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic [1:0]  input_channel_select_i,
   input wire logic        serial_input_0_i,
   input wire logic        serial_input_1_i,
   input wire logic        serial_input_2_i,
   input wire logic        serial_input_3_i,
   input wire logic        pll_harmonic_i,
   input wire logic [7:0]  host_addr_i,
   input wire logic [15:0] host_rdata_o,
   input wire logic [3:0]  input_buffer_enable_o,
   input wire logic [7:0]  eq_level_o,
   input wire logic        signal_loss_flag_o,
   input wire logic        data_mute_o,
   input wire logic        locked_o
);
   logic [3:0] ins;
   logic       cur;
   logic       prev;
   logic [1:0] psel;
   logic       edg;
   logic [9:0] quiet;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // ==========================================
   // Quiet time on the selected input
   assign ins = {serial_input_3_i, serial_input_2_i, serial_input_1_i, serial_input_0_i};
   assign cur = ins[input_channel_select_i];
   assign edg = (cur != prev) && (input_channel_select_i == psel);
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prev  <= 1'b0;
         psel  <= 2'h0;
         quiet <= 10'h000;
      end
      else
      begin
         prev <= cur;
         psel <= input_channel_select_i;
         if (edg || input_channel_select_i != psel)
            quiet <= 10'h000;
         else if (quiet != 10'h3ff)
            quiet <= quiet + 10'h001;
      end
   end
   // ==========================================
   // Checks
   a_mute_on_loss:
      assert property ($rose(signal_loss_flag_o) |=> data_mute_o)
      else $error("mute missed");
   a_sel_buffer_on:
      assert property ($stable(input_channel_select_i) [*7]
         |-> input_buffer_enable_o == (4'h1 << input_channel_select_i))
      else $error("buffer enable wrong");
   a_unsel_eq_off:
      assert property ($stable(input_channel_select_i) [*7]
         |-> (eq_level_o & ~(8'h03 << {input_channel_select_i, 1'b0})) == 8'h00)
      else $error("unselected eq on");
   a_loss_not_early:
      assert property ($rose(signal_loss_flag_o) |-> quiet >= 10'h0be)
      else $error("loss flag early");
   a_loss_not_late:
      assert property (quiet == 10'h1a4 |-> signal_loss_flag_o)
      else $error("loss flag late");
   a_loss_clears:
      assert property (signal_loss_flag_o && edg |-> ##[1:200] !signal_loss_flag_o)
      else $error("loss flag stuck");
   a_harm_no_lock:
      assert property (pll_harmonic_i [*8] |-> !locked_o)
      else $error("lock on harmonic");
   a_unmapped_zero:
      assert property (host_addr_i != 8'h02 |=> host_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
endmodule // sdils_top_asserts
`default_nettype wire

// *** tb/sdils_src_model.sv ***
// Serial video source model feeding the four inputs
`timescale 1ns/1ps
`default_nettype none
module sdils_src_model
(
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic [3:0] live_i,
   output var  logic [3:0] ser_o,
   output var  logic [3:0] amp_o
);
   // ==========================================
   // Stream
   // Each level stands two samples so the pin filter passes it
   logic [1:0] ph;
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ph    <= 2'h0;
         ser_o <= 4'h0;
      end
      else
      begin
         ph    <= ph + 2'h1;
         ser_o <= live_i & {4{ph[1]}};
      end
   end
   assign amp_o = live_i;
endmodule // sdils_src_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the input monitor top
`timescale 1ns/1ps
`default_nettype none
`default_nettype none
module testbench
   import sdils_pkg::*;
;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, host_interface_select_n = 1'b0, out_ready_i = 1'b0;
   logic [3:0]  eq_pins = 4'h0, live = 4'hf, ser, amp, input_buffer_enable_o;
   logic [1:0]  input_channel_select_i = 2'h0, los_threshold_o;
   logic        pll_freq_ok_i = 1'b0, pll_phase_ok_i = 1'b0, pll_harmonic_i = 1'b0;
   logic        host_wr_i = 1'b0, los_method_o, signal_loss_flag_o, data_mute_o;
   logic        locked_o, out_valid_o, ref_hold_o, lock_retry_o;
   logic [7:0]  host_addr_i = 8'h00, eq_level_o, out_data_o;
   logic [15:0] host_wdata_i = 16'h0000, host_rdata_o, rd, m_reg;
   logic [16:0] rnd = 17'h104f1;
   int          error_cnt = 0, compares = 0, t;
   sdils_top #(.LOCK_TIMEOUT_CYC(50)) i_sdils_top
   (
      .*, .host_interface_select_n_i(host_interface_select_n), .spi_mosi_eq0_i(eq_pins[0]),
      .spi_miso_eq1_i(eq_pins[1]), .spi_sck_eq2_i(eq_pins[2]), .spi_cs_eq3_i(eq_pins[3]),
      .serial_input_0_i(ser[0]), .serial_input_1_i(ser[1]), .serial_input_2_i(ser[2]),
      .serial_input_3_i(ser[3]), .amp_ok_i(amp)
   );
   sdils_src_model i_sdils_src_model (.*, .live_i(live), .ser_o(ser), .amp_o(amp));
   always #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) out_ready_i <= rnd[0];
   // ==========================================
   // Helpers and reference model
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   function automatic logic [7:0] exp_eq(input logic [1:0] s);
      logic [1:0] lv;
      lv = host_interface_select_n ? (eq_pins[s] ? SDILS_EQ_MED : SDILS_EQ_LOW) : m_reg[4:3];
      return {6'h00, lv} << {s, 1'b0};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      host_wr_i <= 1'b1;
      host_addr_i <= a;
      host_wdata_i <= d;
      @(posedge mclk_i);
      host_wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk_i);
      host_addr_i <= a;
      cyc(2);
      #1 rd = host_rdata_o;
   endtask
   task automatic results();
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial
   begin
      cyc(12);
      rst_b_i <= 1'b1;
      cyc(2);
      m_reg = 16'h0008;
      rd_reg(8'h02);
      chk(rd, m_reg);
      for (t = 0; t < 4; t++)
      begin
         rnd = lfsr(rnd);
         m_reg = {11'h000, rnd[1:0], t[1:0], 1'b1};
         wr_reg(8'h02, {rnd[15:5], m_reg[4:0]});
         wr_reg(8'h07, rnd[15:0]);
         rd_reg(8'h02);
         chk({3'h0, rd[12:0]}, m_reg);
         chk({13'h0, los_threshold_o, los_method_o}, m_reg & 16'h0007);
      end
      $display("end regs");
      for (t = 0; t < 8; t++)
      begin
         rnd = lfsr(rnd);
         host_interface_select_n <= t[2];
         input_channel_select_i <= t[1:0];
         eq_pins <= rnd[3:0];
         cyc(8);
         chk({12'h0, input_buffer_enable_o}, 16'h1 << t[1:0]);
         chk({8'h0, eq_level_o}, {8'h0, exp_eq(t[1:0])});
      end
      m_reg = 16'h0008;
      wr_reg(8'h02, 16'h0007);
      rd_reg(8'h02);
      chk({3'h0, rd[12:0]}, m_reg);
      chk({15'h0, los_method_o}, 16'h0000);
      $display("end select");
      live <= 4'h0;
      for (t = 0; t < 500 && signal_loss_flag_o !== 1'b1; t++) cyc(1);
      chk(16'(t >= 190 && t <= 420), 16'h0001);
      cyc(16);
      chk({7'h0, data_mute_o, out_data_o}, 16'h01ff);
      live <= 4'hf;
      for (t = 0; t < 500 && signal_loss_flag_o !== 1'b0; t++) cyc(1);
      chk(16'(t <= 205), 16'h0001);
      $display("end loss");
      host_interface_select_n <= 1'b0;
      pll_freq_ok_i <= 1'b1;
      pll_phase_ok_i <= 1'b1;
      for (t = 0; t < 600 && locked_o !== 1'b1; t++) cyc(1);
      chk(16'(t >= 400 && t <= 410), 16'h0001);
      rd_reg(8'h02);
      chk({13'h0, rd[15], ref_hold_o, lock_retry_o}, 16'h0004);
      pll_harmonic_i <= 1'b1;
      cyc(10);
      chk({14'h0, locked_o, ref_hold_o}, 16'h0001);
      $display("end lock");
      results();
   end
   // Tests need about 1000 cycles
   initial
   begin
      cyc(5000);
      error_cnt++;
      results();
   end
endmodule // testbench
bind sdils_top sdils_top_asserts i_sdils_top_asserts (.*);
`default_nettype wire
